// ==== logic/sbrl_pkg.sv ====
// Constants and carrier types for the serial bootstrap RAM loader.
// Assumes one 10 MHz core clock; serial timing derives from it.
`default_nettype none

package sbrl_pkg;
    // Clock periods: core clock and the processor E clock
    localparam int CORE_PERIOD_NS   = 100;
    localparam int E_PERIOD_NS      = 500;
    // Serial rates in baud
    localparam int FAST_BAUD        = 7812;
    localparam int SLOW_BAUD        = 1200;
    localparam int FAST_BIT_CYC     = 1000000000 / (FAST_BAUD * CORE_PERIOD_NS);
    localparam int SLOW_BIT_CYC     = 1000000000 / (SLOW_BAUD * CORE_PERIOD_NS);
    // Idle timeout at the fast rate, in E cycles, then in core cycles
    localparam int TIMEOUT_E_CYC    = 10241;
    localparam int TIMEOUT_FAST_CYC = TIMEOUT_E_CYC * E_PERIOD_NS / CORE_PERIOD_NS;
    localparam int TIMEOUT_SLOW_CYC = TIMEOUT_FAST_CYC * SLOW_BIT_CYC / FAST_BIT_CYC;
    localparam int FRAME_BITS       = 10;
    localparam int RAM_BYTES        = 512;
    localparam int ADDR_W           = 16;
    localparam int CNT_W            = 20;
    localparam int BIT_W            = 14;
    localparam int LEN_W            = 10;
    localparam logic [ADDR_W-1:0] EEPROM_START = 16'hb600;
    localparam logic [ADDR_W-1:0] RAM_START    = 16'h0000;
    localparam logic [7:0] BYTE_BREAK = 8'h00;
    localparam logic [7:0] BYTE_ONES  = 8'hff;
    localparam logic [7:0] BYTE_SLOWA = 8'he0;
    localparam logic [7:0] BYTE_SLOWB = 8'hc0;
    // Index values for the programming routine (arbitrary defaults)
    localparam logic [ADDR_W-1:0] IDX_X_INIT = 16'h0000;
    localparam logic [ADDR_W-1:0] IDX_Y_INIT = 16'h0000;

    typedef enum logic [4:0] {
        ST_BREAK = 5'b00001,
        ST_FIRST = 5'b00010,
        ST_LOAD  = 5'b00100,
        ST_DRAIN = 5'b01000,
        ST_DONE  = 5'b10000
    } sbrl_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } sbrl_ram_write_t;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
    } sbrl_jump_t;
endpackage : sbrl_pkg

`default_nettype wire

// ==== logic/sbrl_skid_buf.sv ====
// Two-entry buffer with valid and ready on both sides.
// Assumes the same clock and reset as its user.
`default_nettype none

module sbrl_skid_buf #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             resetn,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] mem [2];
    logic             wrPtr_reg;
    logic             rdPtr_reg;
    logic [1:0]       count_reg;
    logic             push;
    logic             pop;

    assign inReady  = (count_reg != 2'h2);
    assign outValid = (count_reg != 2'h0);
    assign outData  = mem[rdPtr_reg];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_reg <= 1'b0;
            rdPtr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            if (push) begin
                wrPtr_reg <= ~wrPtr_reg;
            end
            if (pop) begin
                rdPtr_reg <= ~rdPtr_reg;
            end
            case ({push, pop})
                2'b10:   count_reg <= count_reg + 2'h1;
                2'b01:   count_reg <= count_reg - 2'h1;
                default: count_reg <= count_reg;
            endcase
        end
    end
endmodule : sbrl_skid_buf

`default_nettype wire

// ==== logic/sbrl_loader.sv ====
// Serial bootstrap loader: receives a program and writes it to RAM.
// Assumes a RAM write port with ready and a receive pin from outside.
//
// Summary of operation
// - After reset the loader sends a break on its transmit line before taking the first byte.
// - A first byte of zero makes the loader jump at once to the start of EEPROM.
// - The host opens with an all-ones byte, which keeps the fast default rate.
// - A first byte seen as 0xE0 or 0xC0 switches the serial rate to the slow rate.
// - On the slow rate the idle timeout constant is scaled to the longer character time.
// - The RAM pointer is set to address zero before the download loop starts.
// - Downloads run from 0 to 512 bytes and the host ends one by four idle character times.
// - The idle timeout at the fast rate is 10,241 E cycles, just over four character times.
// - The idle timeout does not run before a first byte of all ones, 0xE0 or 0xC0 has arrived.
// - A lone all-ones byte ends in a jump to RAM with no RAM location written.
// - Each downloaded byte is written to RAM at the pointer and echoed to the host.
// - The pointer steps after each store and the loop ends on timeout or a full RAM.
// - At the end the index values are loaded and the loader jumps to the start of RAM.
// - With 256 bytes of RAM the download is exactly 256 bytes and no timeout applies.
`default_nettype none

module sbrl_loader
    import sbrl_pkg::*;
#(
    parameter int RAM_SIZE     = sbrl_pkg::RAM_BYTES,
    parameter int FAST_BIT     = sbrl_pkg::FAST_BIT_CYC,
    parameter int SLOW_BIT     = sbrl_pkg::SLOW_BIT_CYC,
    parameter int TIMEOUT_FAST = sbrl_pkg::TIMEOUT_FAST_CYC,
    parameter int TIMEOUT_SLOW = sbrl_pkg::TIMEOUT_SLOW_CYC
) (
    input  wire logic                     core_clk,
    input  wire logic                     resetn,
    input  wire logic                     rxdPin,
    input  wire logic                     ramReady,
    output logic                          txdOut,
    output logic                          ramWe,
    output sbrl_pkg::sbrl_ram_write_t     ramWrite,
    output sbrl_pkg::sbrl_jump_t          jump,
    output logic [sbrl_pkg::ADDR_W-1:0]   indexX,
    output logic [sbrl_pkg::ADDR_W-1:0]   indexY,
    output logic                          slowRate,
    output logic                          overrun
);
    import sbrl_pkg::*;

    localparam logic            FIXED_LEN = (RAM_SIZE == 256);
    localparam logic [LEN_W:0]  LEN_FULL  = (LEN_W+1)'(RAM_SIZE);
    localparam logic [BIT_W-1:0] FAST_B   = BIT_W'(FAST_BIT - 1);
    localparam logic [BIT_W-1:0] SLOW_B   = BIT_W'(SLOW_BIT - 1);
    localparam logic [CNT_W-1:0] TO_FAST  = CNT_W'(TIMEOUT_FAST);
    localparam logic [CNT_W-1:0] TO_SLOW  = CNT_W'(TIMEOUT_SLOW);

    sbrl_state_t       state_reg;
    logic              rxS1_reg;
    logic              rxS2_reg;
    logic              rxS3_reg;
    logic              rxLevel_reg;
    logic              rxBusy_reg;
    logic              rxArmed_reg;
    logic [3:0]        rxIdx_reg;
    logic [BIT_W-1:0]  rxTimer_reg;
    logic [7:0]        rxShift_reg;
    logic              rxDone_reg;
    logic              txBusy_reg;
    logic [3:0]        txIdx_reg;
    logic [BIT_W-1:0]  txTimer_reg;
    logic [9:0]        txShift_reg;
    logic              breakSent_reg;
    logic [CNT_W-1:0]  toCnt_reg;
    logic [LEN_W:0]    rxCount_reg;
    logic [ADDR_W-1:0] ptr_reg;
    logic [BIT_W-1:0]  bitCyc;
    logic              firstChar;
    logic              firstSlow;
    logic              firstGo;
    logic              loadByte;
    logic              bufInReady;
    logic              bufOutValid;
    logic [7:0]        bufOutData;
    logic              pop;
    logic              txLoadBreak;
    logic              drained;
    logic              timedOut;
    logic              full;

    assign bitCyc      = slowRate ? SLOW_B : FAST_B;
    assign firstChar   = rxDone_reg && (state_reg == ST_BREAK || state_reg == ST_FIRST);
    assign firstSlow   = (rxShift_reg == BYTE_SLOWA) || (rxShift_reg == BYTE_SLOWB);
    assign firstGo     = firstChar && ((rxShift_reg == BYTE_ONES) || firstSlow);
    assign full        = (rxCount_reg == LEN_FULL);
    assign loadByte    = rxDone_reg && (state_reg == ST_LOAD) && !full;
    assign txLoadBreak = (state_reg == ST_BREAK) && !txBusy_reg && !breakSent_reg;
    assign pop         = bufOutValid && ramReady && (!txBusy_reg
                         || (txIdx_reg == 4'(FRAME_BITS - 1) && txTimer_reg == '0));
    assign drained     = !bufOutValid && !txBusy_reg;
    assign timedOut    = !FIXED_LEN && (toCnt_reg == '0);

    // Pin passes three flops; level changes when the last two agree
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rxS1_reg    <= 1'b1;
            rxS2_reg    <= 1'b1;
            rxS3_reg    <= 1'b1;
            rxLevel_reg <= 1'b1;
        end else begin
            rxS1_reg <= rxdPin;
            rxS2_reg <= rxS1_reg;
            rxS3_reg <= rxS2_reg;
            if (rxS2_reg == rxS3_reg) begin
                rxLevel_reg <= rxS3_reg;
            end
        end
    end

    // Receiver samples mid-bit; a break arrives as a zero byte.
    // Re-arms only after the line returns high, so a long break counts once.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rxBusy_reg  <= 1'b0;
            rxArmed_reg <= 1'b0;
            rxIdx_reg   <= 4'h0;
            rxTimer_reg <= '0;
            rxShift_reg <= 8'h00;
            rxDone_reg  <= 1'b0;
        end else begin
            rxDone_reg <= 1'b0;
            if (!rxBusy_reg) begin
                if (rxLevel_reg) begin
                    rxArmed_reg <= 1'b1;
                end else if (rxArmed_reg) begin
                    rxBusy_reg  <= 1'b1;
                    rxArmed_reg <= 1'b0;
                    rxIdx_reg   <= 4'h0;
                    rxTimer_reg <= bitCyc >> 1;
                end
            end else if (rxTimer_reg != '0) begin
                rxTimer_reg <= rxTimer_reg - 1'b1;
            end else begin
                rxTimer_reg <= bitCyc;
                rxIdx_reg   <= rxIdx_reg + 4'h1;
                if (rxIdx_reg == 4'h0 && rxLevel_reg) begin
                    rxBusy_reg  <= 1'b0;
                end else if (rxIdx_reg >= 4'h1 && rxIdx_reg <= 4'h8) begin
                    rxShift_reg <= {rxLevel_reg, rxShift_reg[7:1]};
                end else if (rxIdx_reg == 4'h9) begin
                    rxBusy_reg <= 1'b0;
                    rxDone_reg <= 1'b1;
                end
            end
        end
    end

    // Received bytes wait here while the echo is still going out
    sbrl_skid_buf #(
        .WIDTH (8)
    ) u_buf (
        .core_clk (core_clk),
        .resetn   (resetn),
        .inValid  (loadByte),
        .inReady  (bufInReady),
        .inData   (rxShift_reg),
        .outValid (bufOutValid),
        .outReady (pop),
        .outData  (bufOutData)
    );

    // Transmitter shifts LSB first; break is ten low bits
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            txBusy_reg    <= 1'b0;
            txIdx_reg     <= 4'h0;
            txTimer_reg   <= '0;
            txShift_reg   <= 10'h3ff;
            txdOut        <= 1'b1;
            breakSent_reg <= 1'b0;
        end else if (txLoadBreak) begin
            txBusy_reg    <= 1'b1;
            breakSent_reg <= 1'b1;
            txShift_reg   <= 10'h000;
            txdOut        <= 1'b0;
            txIdx_reg     <= 4'h0;
            txTimer_reg   <= bitCyc;
        end else if (pop) begin
            txBusy_reg  <= 1'b1;
            txShift_reg <= {1'b1, bufOutData, 1'b0};
            txdOut      <= 1'b0;
            txIdx_reg   <= 4'h0;
            txTimer_reg <= bitCyc;
        end else if (txBusy_reg) begin
            if (txTimer_reg != '0) begin
                txTimer_reg <= txTimer_reg - 1'b1;
            end else if (txIdx_reg == 4'(FRAME_BITS - 1)) begin
                txBusy_reg <= 1'b0;
                txdOut     <= 1'b1;
            end else begin
                txTimer_reg <= bitCyc;
                txIdx_reg   <= txIdx_reg + 4'h1;
                txShift_reg <= {1'b1, txShift_reg[9:1]};
                txdOut      <= txShift_reg[1];
            end
        end
    end

    // Sequencer
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_BREAK;
        end else begin
            case (state_reg)
                ST_BREAK, ST_FIRST: begin
                    if (firstChar && rxShift_reg == BYTE_BREAK) begin
                        state_reg <= ST_DONE;
                    end else if (firstGo) begin
                        state_reg <= ST_LOAD;
                    end else if (state_reg == ST_BREAK && breakSent_reg && !txBusy_reg) begin
                        state_reg <= ST_FIRST;
                    end
                end
                ST_LOAD: begin
                    if (full || (timedOut && !rxDone_reg)) begin
                        state_reg <= ST_DRAIN;
                    end
                end
                ST_DRAIN: begin
                    if (drained) begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE:  state_reg <= ST_DONE;
                default:  state_reg <= ST_BREAK;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            slowRate <= 1'b0;
        end else if (firstChar && firstSlow) begin
            slowRate <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            toCnt_reg <= TO_FAST;
        end else if (firstGo) begin
            toCnt_reg <= firstSlow ? TO_SLOW : TO_FAST;
        end else if (state_reg == ST_LOAD) begin
            if (rxDone_reg) begin
                toCnt_reg <= slowRate ? TO_SLOW : TO_FAST;
            end else if (toCnt_reg != '0) begin
                toCnt_reg <= toCnt_reg - 1'b1;
            end
        end
    end

    // RAM pointer, write port and byte count
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ptr_reg     <= RAM_START;
            rxCount_reg <= '0;
            ramWe       <= 1'b0;
            ramWrite    <= '0;
            overrun     <= 1'b0;
        end else begin
            ramWe <= 1'b0;
            if (firstGo) begin
                ptr_reg     <= RAM_START;
                rxCount_reg <= '0;
            end
            if (loadByte) begin
                rxCount_reg <= rxCount_reg + 1'b1;
                if (!bufInReady) begin
                    overrun <= 1'b1;
                end
            end
            if (pop) begin
                ramWe         <= 1'b1;
                ramWrite.addr <= ptr_reg;
                ramWrite.data <= bufOutData;
                ptr_reg       <= ptr_reg + 1'b1;
            end
        end
    end

    // Final jump and index setup
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            jump   <= '0;
            indexX <= '0;
            indexY <= '0;
        end else if (firstChar && rxShift_reg == BYTE_BREAK && !jump.valid) begin
            jump.valid <= 1'b1;
            jump.addr  <= EEPROM_START;
        end else if (state_reg == ST_DRAIN && drained) begin
            jump.valid <= 1'b1;
            jump.addr  <= RAM_START;
            indexX     <= IDX_X_INIT;
            indexY     <= IDX_Y_INIT;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_break_first_out:  assert property (txLoadBreak |=> !txdOut [*3])
        else $error("Break not driven low");
    a_zero_to_eeprom:   assert property (firstChar && rxShift_reg == BYTE_BREAK
        |=> jump.valid && jump.addr == EEPROM_START)
        else $error("Zero byte did not jump to EEPROM");
    a_ones_keep_fast:   assert property (firstChar && rxShift_reg == BYTE_ONES
        |=> !slowRate && state_reg == ST_LOAD)
        else $error("All-ones byte changed rate");
    a_slow_switch:      assert property (firstChar && firstSlow |=> slowRate)
        else $error("Slow rate not taken");
    a_slow_timeout:     assert property (firstChar && firstSlow
        |=> toCnt_reg == TO_SLOW)
        else $error("Timeout not scaled");
    a_ptr_zeroed:       assert property (firstGo |=> ptr_reg == RAM_START)
        else $error("Pointer not cleared");
    a_fast_timeout:     assert property (firstChar && rxShift_reg == BYTE_ONES
        |=> toCnt_reg == TO_FAST ##1 toCnt_reg == TO_FAST - 1'b1)
        else $error("Fast timeout wrong");
    a_no_early_timer:   assert property (state_reg == ST_FIRST && !firstGo
        |=> $stable(toCnt_reg))
        else $error("Timeout ran before first byte");
    a_lone_ones_jump:   assert property (state_reg == ST_LOAD && timedOut
        && rxCount_reg == '0 && !rxDone_reg |=> !ramWe ##1 jump.valid)
        else $error("Lone all-ones did not jump cleanly");
    a_echo_with_write:  assert property (pop |=> ramWe && !txdOut
        && ramWrite.data == $past(bufOutData))
        else $error("Store and echo not paired");
    a_ptr_step:         assert property (pop |=> ptr_reg == $past(ptr_reg) + 1'b1)
        else $error("Pointer did not step");
    a_full_ends:        assert property (state_reg == ST_LOAD && full
        |=> state_reg == ST_DRAIN)
        else $error("Full RAM did not end loop");
    a_ram_jump_index:   assert property (state_reg == ST_DRAIN && drained
        |=> jump.valid && jump.addr == RAM_START && indexX == IDX_X_INIT)
        else $error("RAM jump missing");
    a_reload_on_byte:   assert property (state_reg == ST_LOAD && rxDone_reg
        |=> toCnt_reg == (slowRate ? TO_SLOW : TO_FAST))
        else $error("Timeout not reloaded");

    c_eeprom_jump: cover property (firstChar && rxShift_reg == BYTE_BREAK);
    c_slow_load:   cover property (state_reg == ST_LOAD && slowRate && pop);
    c_timeout_end: cover property (state_reg == ST_LOAD && timedOut ##1 state_reg == ST_DRAIN);
    c_ram_full:    cover property (state_reg == ST_LOAD && full);
endmodule : sbrl_loader

`default_nettype wire

// ==== sim/sbrl_host_model.sv ====
// Host side of the loader: serial sender, echo receiver, RAM write port.
// Assumes the loader's core clock; the pin and ready change at the falling edge.
`default_nettype none

module sbrl_host_model
    import sbrl_pkg::*;
#(
    parameter int FAST = 16,
    parameter int SLOW = 104
) (
    input  wire logic                      core_clk,
    input  wire logic                      slowSel,
    input  wire logic                      stallSel,
    input  wire logic                      txdOut,
    input  wire logic                      ramWe,
    input  wire sbrl_pkg::sbrl_ram_write_t ramWrite,
    output logic                           rxdPin,
    output logic                           ramReady
);
    timeunit 1ns;
    timeprecision 1ns;
    import sbrl_pkg::*;
    logic [7:0]      echoQ[$];
    sbrl_ram_write_t wrQ[$];
    logic [2:0]      stallCnt = 3'h0;
    initial begin
        rxdPin = 1'b1;
        ramReady = 1'b1;
    end
    task automatic send_byte(input logic [7:0] b, input int bitCyc);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxdPin = frame[i];
            repeat (bitCyc) @(negedge core_clk);
        end
    endtask : send_byte
    // Stall half the time, so writes must wait
    always @(negedge core_clk) begin
        stallCnt <= stallCnt + 3'h1;
        ramReady <= !stallSel || stallCnt[2];
    end
    always @(posedge core_clk) begin
        if (ramWe === 1'b1) begin
            wrQ.push_back(ramWrite);
        end
    end
    // Echo receiver; a break also lands here as a zero byte
    always begin : echo_rx
        logic [7:0] b;
        int         bc;
        @(negedge txdOut);
        bc = slowSel ? SLOW : FAST;
        repeat (bc / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (bc) @(posedge core_clk);
            b[i] = txdOut;
        end
        repeat (bc) @(posedge core_clk);
        echoQ.push_back(b);
    end
endmodule : sbrl_host_model

`default_nettype wire

// ==== sim/test_sbrl_loader.sv ====
// Self-checking bench for the serial bootstrap loader.
// Assumes shortened bit and timeout counts set on the instance below.
`default_nettype none

module test_sbrl_loader;
    timeunit 1ns;
    timeprecision 1ns;
    import sbrl_pkg::*;
    localparam int FB = 16;
    localparam int SB = 104;
    localparam int TF = 640;
    localparam int TS = 4160;
    logic              core_clk;
    logic              resetn;
    logic              slowSel;
    logic              stallSel;
    logic              rxdPin;
    logic              ramReady;
    logic              txdOut;
    logic              ramWe;
    logic              slowRate;
    logic              overrun;
    sbrl_ram_write_t   ramWrite;
    sbrl_jump_t        jump;
    logic [ADDR_W-1:0] indexX;
    logic [ADDR_W-1:0] indexY;
    int                error_cnt = 0;
    int                total_checks = 0;
    logic              ramWe2;
    logic              overrun2;
    sbrl_ram_write_t   ramWrite2;
    sbrl_jump_t        jump2;
    int                wr2Cnt = 0;
    logic [ADDR_W-1:0] wr2Last;

    sbrl_loader #(.FAST_BIT(FB), .SLOW_BIT(SB), .TIMEOUT_FAST(TF), .TIMEOUT_SLOW(TS)) DUT (
        .core_clk(core_clk), .resetn(resetn), .rxdPin(rxdPin), .ramReady(ramReady),
        .txdOut(txdOut), .ramWe(ramWe), .ramWrite(ramWrite), .jump(jump),
        .indexX(indexX), .indexY(indexY), .slowRate(slowRate), .overrun(overrun));
    sbrl_host_model #(.FAST(FB), .SLOW(SB)) host (
        .core_clk(core_clk), .slowSel(slowSel), .stallSel(stallSel), .txdOut(txdOut),
        .ramWe(ramWe), .ramWrite(ramWrite), .rxdPin(rxdPin), .ramReady(ramReady));
    // Fixed-length variant listens to the same line; its echo goes nowhere
    sbrl_loader #(.RAM_SIZE(256), .FAST_BIT(FB), .SLOW_BIT(SB), .TIMEOUT_FAST(TF),
        .TIMEOUT_SLOW(TS)) DUT_FIXED (
        .core_clk(core_clk), .resetn(resetn), .rxdPin(rxdPin), .ramReady(ramReady),
        .txdOut(), .ramWe(ramWe2), .ramWrite(ramWrite2), .jump(jump2),
        .indexX(), .indexY(), .slowRate(), .overrun(overrun2));

    always @(negedge core_clk) begin
        if (ramWe2 === 1'b1) begin
            wr2Cnt++;
            wr2Last = ramWrite2.addr;
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic report_and_stop();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_val

    task automatic do_reset();
        resetn = 1'b0;
        slowSel = 1'b0;
        stallSel = 1'b0;
        repeat (4) @(negedge core_clk);
        host.wrQ.delete();
        wr2Cnt = 0;
        resetn = 1'b1;
    endtask : do_reset

    task automatic wait_jump(input int maxCyc);
        int n;
        n = 0;
        while (jump.valid !== 1'b1 && n < maxCyc) begin
            @(negedge core_clk);
            n++;
        end
        if (jump.valid !== 1'b1) begin
            error_cnt++;
            $display("Error t=%0t got=%h exp=%h", $time, jump, {1'b1, 16'h0000});
            report_and_stop();
        end
    endtask : wait_jump

    task automatic t_break_eeprom();
        int lowCnt;
        int n;
        do_reset();
        n = 0;
        while (txdOut !== 1'b0 && n < 10) begin
            @(negedge core_clk);
            n++;
        end
        lowCnt = 0;
        while (txdOut === 1'b0 && lowCnt < 400) begin
            @(negedge core_clk);
            lowCnt++;
        end
        check_val(lowCnt, 10 * FB);
        host.send_byte(BYTE_BREAK, FB);
        wait_jump(100);
        check_val(jump, {1'b1, EEPROM_START});
        check_val(host.wrQ.size(), 0);
    endtask : t_break_eeprom

    task automatic t_load(input logic [7:0] first, input int bc, input int n, input int tmo);
        logic [7:0] d;
        do_reset();
        stallSel = (n > 1);
        repeat (1000) @(negedge core_clk);
        check_val(jump.valid, 1'b0);
        host.echoQ.delete();
        host.send_byte(first, FB);
        slowSel = (bc == SB);
        for (int k = 0; k < n; k++) begin
            host.send_byte(8'h5a ^ 8'(k * 37), bc);
        end
        repeat (tmo - 100) @(negedge core_clk);
        check_val(jump.valid, 1'b0);
        wait_jump(400);
        check_val(jump, {1'b1, RAM_START});
        check_val({indexX, indexY}, {IDX_X_INIT, IDX_Y_INIT});
        check_val(slowRate, bc == SB);
        check_val(host.wrQ.size(), n);
        check_val(host.echoQ.size(), n);
        for (int k = 0; k < n; k++) begin
            d = 8'h5a ^ 8'(k * 37);
            if (k < host.wrQ.size()) begin
                check_val(host.wrQ[k], {RAM_START + 16'(k), d});
            end
            if (k < host.echoQ.size()) begin
                check_val(host.echoQ[k], d);
            end
        end
        check_val(overrun, 1'b0);
    endtask : t_load

    task automatic t_fixed();
        int n;
        do_reset();
        repeat (300) @(negedge core_clk);
        host.send_byte(8'h55, FB);
        host.send_byte(BYTE_ONES, FB);
        for (int k = 0; k < 257; k++) begin
            host.send_byte(8'(k), FB);
            if (k == 127) begin
                repeat (TF + 200) @(negedge core_clk);
                check_val(host.wrQ.size(), 128);
                check_val(jump, {1'b1, RAM_START});
                check_val(jump2.valid, 1'b0);
            end
        end
        n = 0;
        while (jump2.valid !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        check_val(jump2, {1'b1, RAM_START});
        check_val(wr2Cnt, 256);
        check_val(wr2Last, RAM_START + 16'hff);
        check_val(overrun2, 1'b0);
        if (n == 400) begin
            report_and_stop();
        end
    endtask : t_fixed

    initial begin
        resetn = 1'b0;
        slowSel = 1'b0;
        stallSel = 1'b0;
        @(negedge core_clk);
        t_break_eeprom();
        t_load(BYTE_ONES, FB, 0, TF);
        t_load(BYTE_ONES, FB, 4, TF);
        t_load(BYTE_SLOWA, SB, 2, TS);
        t_load(BYTE_SLOWB, SB, 2, TS);
        t_fixed();
        report_and_stop();
    end
endmodule : test_sbrl_loader

`default_nettype wire
